// *** verilog/icel_logger.v ***
// info code supervision, transport state and event logs
//
// Overview of operation
// (R1) bit0 supply lost, bit1 low battery
// (R2) bits 3..6 temperature sensor faults, bit7 bad difference
// (R3) bit8 air, bit9 reverse, bit11 overflow
// (R4) faulty sensor reads clamped min or max
// (R5) fault stops dependent energy accumulation
// (R6) any sensor fault reports power zero
// (R7) bad difference alone is no fault
// (R8) flow fault reports flow zero
// (R9) flow above nominal is no fault
// (R10) transport state until first integration
// (R11) transport state blocks logging and counting; config log entries and cfg_fill still advance in it
// (R12) power saving sequence in transport state
// (R13) finish command closes menu, leaves transport
// (R14) transport only via total reset; seal reopens
// (R15) radio off until first integration or radio menu enable
// (R16) verification menu forces radio off
// (R17) log date, time, word, energies, volume
// (R18) events only for enabled bits
// (R19) mask changes leave logged entries alone
// (R20) config log entry, max 25 entries
// (R21) config logged whenever menu accessed
// (R22) time stored standard, offset applied on read
// (R23) event counter increments per change
// (R24) word is sum of bit values
// (R25) info log circular, oldest overwritten
`timescale 1ns/10ps
`include "icel_defs.vh"
module icel_logger (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        supply_lost,
  input  wire        battery_low,
  input  wire        inlet_high,
  input  wire        outlet_high,
  input  wire        inlet_low,
  input  wire        outlet_low,
  input  wire        diff_invalid,
  input  wire        flow_air,
  input  wire        flow_reverse,
  input  wire        flow_over_limit,
  input  wire        flow_registered,
  input  wire        total_reset,
  input  wire        finish_configuration_command,
  input  wire        seal_contact,
  input  wire        menu_left,
  input  wire        radio_menu_enable,
  input  wire        verify_menu,
  input  wire        dst_offset_now,
  input  wire [31:0] std_time,
  input  wire [31:0] heat_energy_count,
  input  wire [31:0] cooling_energy_count,
  input  wire [31:0] volume_count,
  input  wire [31:0] hour_count,
  input  wire [15:0] temp_offset,
  input  wire [31:0] config_number,
  input  wire [15:0] inlet_temperature,
  input  wire [15:0] outlet_temperature,
  input  wire [31:0] flow_channel,
  input  wire [31:0] power_now,
  output reg         transport_state,
  output reg         config_menu_open,
  output reg         radio_enable,
  output wire        power_save_sequence,
  output reg         heat_accum_enable,
  output reg         cool_accum_enable,
  output reg         volume_accum_enable,
  output reg         show_dashes_temp,
  output reg         show_dashes_flow,
  output wire        info_active
);
  reg  [11:0] info;
  reg  [11:0] info_prev;
  reg  [11:0] event_mask;
  reg  [31:0] event_count;
  reg  [5:0]  info_wr;
  reg  [5:0]  info_fill;
  reg  [5:0]  log_sel;
  reg  [4:0]  cfg_fill;
  reg         menu_used;
  reg         dst_enable;
  reg  [11:0] log_info   [0:`ICEL_INFO_LOG_DEPTH-1];
  reg  [31:0] log_time   [0:`ICEL_INFO_LOG_DEPTH-1];
  reg         log_dst    [0:`ICEL_INFO_LOG_DEPTH-1];
  reg  [31:0] log_heat   [0:`ICEL_INFO_LOG_DEPTH-1];
  reg  [31:0] log_cool   [0:`ICEL_INFO_LOG_DEPTH-1];
  reg  [31:0] log_vol    [0:`ICEL_INFO_LOG_DEPTH-1];
  reg  [31:0] cfg_time   [0:`ICEL_CFG_LOG_DEPTH-1];
  reg         cfg_dst    [0:`ICEL_CFG_LOG_DEPTH-1];
  reg  [31:0] cfg_num    [0:`ICEL_CFG_LOG_DEPTH-1];
  reg  [31:0] cfg_hours  [0:`ICEL_CFG_LOG_DEPTH-1];
  reg  [15:0] cfg_offset [0:`ICEL_CFG_LOG_DEPTH-1];
  wire [11:0] next_info;
  wire        t_in_fault;
  wire        t_out_fault;
  wire        t_fault;
  wire        f_fault;
  wire        info_event;
  wire        cfg_log;
  wire        bus_wr;
  wire        bus_rd;
  wire [5:0]  sel_idx;
  wire [4:0]  cfg_idx;
  wire [11:0] bit_change;
  wire [`ICEL_INFO_LOG_DEPTH-1:0] info_valid;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  genvar      gb;
  genvar      ge;

  localparam ST_TRANSPORT = 3'b001;
  localparam ST_MENU_OPEN = 3'b010;
  localparam ST_SEALED    = 3'b100;

  // stamps stay in standard time; the offset is added only on readout
  function [31:0] dst_adjust;
    input [31:0] stamp;
    input        use_offset;
    begin
      dst_adjust = stamp + (use_offset ? `ICEL_DST_SECONDS : 32'h00000000); // R22
    end
  endfunction

  // word is the sum of individual bit values; bit 2 and 10 stay zero
  assign next_info = {flow_over_limit, 1'b0, flow_reverse, flow_air,       // R3 R24
                      diff_invalid, outlet_low, inlet_low,                 // R2
                      outlet_high, inlet_high, 1'b0,
                      battery_low, supply_lost};                           // R1
  // a bad difference alone never counts as a sensor fault
  assign t_in_fault  = inlet_high | inlet_low;                             // R7
  assign t_out_fault = outlet_high | outlet_low;
  assign t_fault     = t_in_fault | t_out_fault;
  // over the nominal limit is not a flow fault, only air or reverse
  assign f_fault     = flow_air | flow_reverse;                            // R9
  assign info_active = |info;
  // per-bit compare on the live mask: old entries are never rewritten
  generate
    for (gb = 0; gb < `ICEL_INFO_W; gb = gb + 1) begin : g_bit
      assign bit_change[gb] = (info[gb] ^ info_prev[gb]) & event_mask[gb]; // R18 R19
    end
  endgenerate
  assign info_event  = ~transport_state & (|bit_change);                   // R11
  assign cfg_log     = menu_used & (menu_left | finish_configuration_command) &
                       (cfg_fill < `ICEL_CFG_LOG_DEPTH);                   // R20 R21
  assign power_save_sequence = transport_state;                            // R12
  assign bus_wr  = psel & penable & pwrite;
  assign bus_rd  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign sel_idx = (log_sel < `ICEL_INFO_LOG_DEPTH) ? log_sel : 6'd0;
  assign cfg_idx = (log_sel < `ICEL_CFG_LOG_DEPTH) ? log_sel[4:0] : 5'd0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info      <= 12'h000;
      info_prev <= 12'h000;
    end else begin
      info      <= next_info;
      info_prev <= info;
    end
  end

  // one-hot mode: transport, running with menu open, running with menu sealed
  always @* begin
    next_state = state;
    case (state)
      ST_TRANSPORT: begin
        if (finish_configuration_command)
          next_state = ST_SEALED;                                          // R13
        else if (flow_registered)
          next_state = ST_MENU_OPEN;                                       // R10
      end
      ST_MENU_OPEN: begin
        if (finish_configuration_command)
          next_state = ST_SEALED;                                          // R13
      end
      ST_SEALED: begin
        // only the contact under the seal label or a total reset reopens the menu
        if (seal_contact)
          next_state = ST_MENU_OPEN;                                       // R14
      end
      default: begin
        next_state = ST_TRANSPORT;
      end
    endcase
    // a total reset is the only way back into transport state
    if (total_reset)
      next_state = ST_TRANSPORT;                                           // R14
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= ST_TRANSPORT;
      transport_state  <= 1'b1;
      config_menu_open <= 1'b1;
      radio_enable     <= 1'b0;
      menu_used        <= 1'b0;
    end else begin
      state            <= next_state;
      transport_state  <= (next_state == ST_TRANSPORT);                    // R10 R13
      config_menu_open <= (next_state != ST_SEALED);                       // R13 R14
      if (total_reset) begin
        radio_enable <= 1'b0;                                              // R14
        menu_used    <= 1'b0;
      end else begin
        if (config_menu_open & ~menu_left & ~finish_configuration_command)
          menu_used <= 1'b1;                                               // R21
        else if (cfg_log)
          menu_used <= 1'b0;
        // verification menu wins over integration and menu enable
        if (verify_menu)
          radio_enable <= 1'b0;                                            // R16
        else if ((transport_state & flow_registered) |
                 (config_menu_open & radio_menu_enable))
          radio_enable <= 1'b1;                                            // R15
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_accum_enable   <= 1'b0;
      cool_accum_enable   <= 1'b0;
      volume_accum_enable <= 1'b0;
      show_dashes_temp    <= 1'b0;
      show_dashes_flow    <= 1'b0;
    end else begin
      heat_accum_enable   <= ~t_fault & ~f_fault;                          // R5
      cool_accum_enable   <= ~t_fault & ~f_fault;                          // R5
      volume_accum_enable <= ~f_fault;                                     // R5
      show_dashes_temp    <= t_fault;                                      // R5
      show_dashes_flow    <= f_fault | t_fault;                            // R5
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_count <= 32'h00000000;
      info_wr     <= 6'd0;
      info_fill   <= 6'd0;
      cfg_fill    <= 5'd0;
      event_mask  <= `ICEL_MASK_RESET;
      log_sel     <= 6'd0;
      dst_enable  <= 1'b0;
    end else begin
      if (total_reset)
        cfg_fill <= 5'd0;                                                  // R20
      else if (cfg_log)
        cfg_fill <= cfg_fill + 5'd1;                                       // R20
      if (info_event) begin
        event_count <= event_count + 32'h00000001;                         // R23
        // wrap index overwrites oldest entry once full
        info_wr <= (info_wr == `ICEL_INFO_LOG_DEPTH - 1) ? 6'd0 : info_wr + 6'd1; // R25
        if (info_fill < `ICEL_INFO_LOG_DEPTH)
          info_fill <= info_fill + 6'd1;
      end
      if (bus_wr) begin
        if (paddr == `ICEL_A_CONTROL)
          dst_enable <= pwdata[0];
        else if (paddr == `ICEL_A_MASK)
          event_mask <= pwdata[11:0];                                      // R19
        else if (paddr == `ICEL_A_LOG_SEL)
          log_sel <= pwdata[5:0];
      end
    end
  end

  // entries hold no reset: per-entry flags mark valid info slots, cfg_fill marks valid config slots
  always @(posedge pclk) begin
    if (info_event) begin
      log_info[info_wr] <= info;                                           // R17
      log_time[info_wr] <= std_time;                                       // R22
      log_dst[info_wr]  <= dst_offset_now;                                 // R22
      log_heat[info_wr] <= heat_energy_count;                              // R17
      log_cool[info_wr] <= cooling_energy_count;                           // R17
      log_vol[info_wr]  <= volume_count;                                   // R17
    end
    if (cfg_log) begin
      cfg_time[cfg_fill]   <= std_time;                                    // R20
      cfg_dst[cfg_fill]    <= dst_offset_now;
      cfg_num[cfg_fill]    <= config_number;
      cfg_hours[cfg_fill]  <= hour_count;
      cfg_offset[cfg_fill] <= temp_offset;
    end
  end

  // per-entry valid flag so that the info word of slots never written reads back as zero
  generate
    for (ge = 0; ge < `ICEL_INFO_LOG_DEPTH; ge = ge + 1) begin : g_entry
      reg entry_used;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          entry_used <= 1'b0;
        else if (info_event && (info_wr == ge))
          entry_used <= 1'b1;                                              // R25
      end
      assign info_valid[ge] = entry_used;
    end
  endgenerate

  // read mux; data loads in the setup cycle so pready can stay tied high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (paddr == `ICEL_A_INFO)
        prdata <= {20'h00000, info};                                       // R24
      else if (paddr == `ICEL_A_STATUS)
        prdata <= {12'h000, cfg_fill, info_fill, info_wr,
                   radio_enable, config_menu_open, transport_state};
      else if (paddr == `ICEL_A_CONTROL)
        prdata <= {31'h00000000, dst_enable};
      else if (paddr == `ICEL_A_EVENT_CNT)
        prdata <= event_count;
      else if (paddr == `ICEL_A_MASK)
        prdata <= {20'h00000, event_mask};
      else if (paddr == `ICEL_A_LOG_SEL)
        prdata <= {26'h0000000, log_sel};
      else if (paddr == `ICEL_A_LOG_INFO)
        prdata <= info_valid[sel_idx] ? {20'h00000, log_info[sel_idx]} :
                  32'h00000000;                                            // R17
      else if (paddr == `ICEL_A_LOG_TIME)
        prdata <= dst_adjust(log_time[sel_idx], dst_enable & log_dst[sel_idx]); // R22
      else if (paddr == `ICEL_A_LOG_HEAT)
        prdata <= log_heat[sel_idx];
      else if (paddr == `ICEL_A_LOG_COOL)
        prdata <= log_cool[sel_idx];
      else if (paddr == `ICEL_A_LOG_VOL)
        prdata <= log_vol[sel_idx];
      else if (paddr == `ICEL_A_CFG_TIME)
        prdata <= dst_adjust(cfg_time[cfg_idx], dst_enable & cfg_dst[cfg_idx]); // R22
      else if (paddr == `ICEL_A_CFG_NUM)
        prdata <= cfg_num[cfg_idx];
      else if (paddr == `ICEL_A_CFG_HOURS)
        prdata <= cfg_hours[cfg_idx];
      else if (paddr == `ICEL_A_CFG_OFFSET)
        prdata <= {16'h0000, cfg_offset[cfg_idx]};
      else if (paddr == `ICEL_A_T_IN)
        prdata <= {16'h0000, inlet_low ? `ICEL_TEMP_MIN :
                   (inlet_high ? `ICEL_TEMP_MAX : inlet_temperature)};     // R4
      else if (paddr == `ICEL_A_T_OUT)
        prdata <= {16'h0000, outlet_low ? `ICEL_TEMP_MIN :
                   (outlet_high ? `ICEL_TEMP_MAX : outlet_temperature)};   // R4
      else if (paddr == `ICEL_A_FLOW)
        prdata <= f_fault ? 32'h00000000 : flow_channel;                   // R8
      else if (paddr == `ICEL_A_POWER)
        prdata <= (t_fault | f_fault) ? 32'h00000000 : power_now;          // R6
      else
        prdata <= 32'h00000000;
    end
  end
endmodule // icel_logger

// *** verilog/icel_defs.vh ***
// constants for the info code event logger
`ifndef ICEL_DEFS_VH
`define ICEL_DEFS_VH
`define ICEL_BIT_SUPPLY      0
`define ICEL_BIT_BATTERY     1
`define ICEL_BIT_T_IN_HIGH   3
`define ICEL_BIT_T_OUT_HIGH  4
`define ICEL_BIT_T_IN_LOW    5
`define ICEL_BIT_T_OUT_LOW   6
`define ICEL_BIT_DT_BAD      7
`define ICEL_BIT_AIR         8
`define ICEL_BIT_REVERSE     9
`define ICEL_BIT_OVERFLOW    11
`define ICEL_INFO_W          12
`define ICEL_INFO_LOG_DEPTH  50
`define ICEL_CFG_LOG_DEPTH   25
`define ICEL_TEMP_MIN        16'h0000
`define ICEL_TEMP_MAX        16'h4844
// register byte addresses
`define ICEL_A_INFO          12'h000
`define ICEL_A_STATUS        12'h004
`define ICEL_A_CONTROL       12'h008
`define ICEL_A_EVENT_CNT     12'h00C
`define ICEL_A_MASK          12'h010
`define ICEL_A_LOG_SEL       12'h014
`define ICEL_A_LOG_INFO      12'h018
`define ICEL_A_LOG_TIME      12'h01C
`define ICEL_A_LOG_HEAT      12'h020
`define ICEL_A_LOG_COOL      12'h024
`define ICEL_A_LOG_VOL       12'h028
`define ICEL_A_CFG_TIME      12'h02C
`define ICEL_A_CFG_NUM       12'h030
`define ICEL_A_CFG_HOURS     12'h034
`define ICEL_A_CFG_OFFSET    12'h038
`define ICEL_A_T_IN          12'h03C
`define ICEL_A_T_OUT         12'h040
`define ICEL_A_FLOW          12'h044
`define ICEL_A_POWER         12'h048
`define ICEL_MASK_RESET      12'hBFB
// one hour of daylight offset on a seconds time base
`define ICEL_DST_SECONDS     32'h00000E10
`endif

// *** dv/icel_logger_assertions.sv ***
// port assertions for the info code logger
`timescale 1ns/10ps
module icel_logger_chk (
  input wire pclk,
  input wire presetn,
  input wire supply_lost,
  input wire inlet_high,
  input wire outlet_high,
  input wire inlet_low,
  input wire outlet_low,
  input wire flow_air,
  input wire flow_reverse,
  input wire flow_registered,
  input wire total_reset,
  input wire finish_configuration_command,
  input wire verify_menu,
  input wire transport_state,
  input wire config_menu_open,
  input wire radio_enable,
  input wire power_save_sequence,
  input wire heat_accum_enable,
  input wire cool_accum_enable,
  input wire volume_accum_enable,
  input wire show_dashes_temp,
  input wire show_dashes_flow,
  input wire info_active
);
  wire tf = inlet_high | outlet_high | inlet_low | outlet_low;
  wire ff = flow_air | flow_reverse;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  save_seq_a: assert property (power_save_sequence == transport_state)
    else $error("power save sequence differs");
  stay_out_a: assert property (!transport_state && !total_reset |=> !transport_state)
    else $error("transport state came back");
  total_rst_a: assert property (total_reset |=> transport_state && !radio_enable)
    else $error("total reset not applied");
  finish_cmd_a: assert property (config_menu_open && finish_configuration_command
    && !total_reset |=> !config_menu_open && !transport_state) else $error("finish ignored");
  radio_on_a: assert property (transport_state && flow_registered && !verify_menu
    && !total_reset |=> radio_enable && !transport_state) else $error("integration missed");
  radio_off_a: assert property (verify_menu [*2] |-> !radio_enable)
    else $error("radio on in verification menu");
  energy_stop_a: assert property (tf || ff |=> !heat_accum_enable && !cool_accum_enable)
    else $error("energy still accumulating");
  vol_stop_a: assert property (ff |=> !volume_accum_enable)
    else $error("volume still accumulating");
  dash_temp_a: assert property (tf |=> show_dashes_temp)
    else $error("temperature dashes missing");
  dash_flow_a: assert property (ff |=> show_dashes_flow)
    else $error("flow dashes missing");
  info_act_a: assert property (supply_lost |=> info_active)
    else $error("info word not active");
endmodule // icel_logger_chk
bind icel_logger icel_logger_chk u_icel_logger_chk (.pclk, .presetn, .supply_lost, .inlet_high,
  .outlet_high, .inlet_low, .outlet_low, .flow_air, .flow_reverse, .flow_registered,
  .total_reset, .finish_configuration_command, .verify_menu, .transport_state,
  .config_menu_open, .radio_enable, .power_save_sequence, .heat_accum_enable,
  .cool_accum_enable, .volume_accum_enable, .show_dashes_temp, .show_dashes_flow, .info_active);

// *** dv/icel_reader.sv ***
// meter reader model speaking apb to the logger
`timescale 1ns/10ps
module icel_reader (
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // request held whole until pready is seen at an edge; no wait count assumed
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    {psel, penable, pwdata} <= {1'b0, 1'b0, ~d};
  endtask
endmodule // icel_reader

// *** dv/tb_top.sv ***
// self-checking bench for the info code logger
`timescale 1ns/10ps
`include "icel_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic        pclk, presetn, pready, pslverr, psel, penable, pwrite, dst;
  logic        transport_state, config_menu_open, radio_enable;
  logic [11:0] paddr, fw, f;
  logic [31:0] pwdata, prdata, q, rv, r0, tm, fl, pw;
  logic [15:0] t_in, t_out;
  logic [6:0]  ctl;
  int          errors, checked, cyc, i, c, p;
  integer      seed;
  icel_logger u_icel_logger (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .supply_lost(fw[0]), .battery_low(fw[1]), .inlet_high(fw[3]),
    .outlet_high(fw[4]), .inlet_low(fw[5]), .outlet_low(fw[6]), .diff_invalid(fw[7]),
    .flow_air(fw[8]), .flow_reverse(fw[9]), .flow_over_limit(fw[11]), .flow_registered(ctl[0]),
    .total_reset(ctl[1]), .finish_configuration_command(ctl[2]), .seal_contact(ctl[5]),
    .menu_left(ctl[6]), .radio_menu_enable(ctl[3]), .verify_menu(ctl[4]), .dst_offset_now(dst),
    .std_time(tm), .heat_energy_count(rv), .cooling_energy_count(~rv), .volume_count(rv),
    .hour_count(rv), .temp_offset(rv[15:0]), .config_number(~rv), .inlet_temperature(t_in),
    .outlet_temperature(t_out), .flow_channel(fl), .power_now(pw), .transport_state,
    .config_menu_open, .radio_enable, .power_save_sequence(), .heat_accum_enable(),
    .cool_accum_enable(), .volume_accum_enable(), .show_dashes_temp(), .show_dashes_flow(),
    .info_active());
  icel_reader u_icel_reader (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  task close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task rd(input logic [11:0] a);
    u_icel_reader.xfer(1'b0, a, 32'h0, q);
  endtask
  task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK(n, e, q)
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_icel_reader.xfer(1'b1, a, d, q);
  endtask
  task pulse(input int k);
    @(posedge pclk);
    ctl[k] <= 1'b1;
    @(posedge pclk);
    ctl[k] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // word registers one cycle, event follows one later: four cycles leaves margin
  task drive(input logic [11:0] v);
    @(posedge pclk);
    fw <= v;
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic [31:0] e_t(input logic lo, hi, input logic [15:0] t);
    return lo ? `ICEL_TEMP_MIN : hi ? `ICEL_TEMP_MAX : {16'h0, t};
  endfunction
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    seed = 32'h9E464DC1;
    presetn = 1'b0;
    {fw, ctl, dst, tm, rv, fl, pw, t_in, t_out} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("transport", 1'b1, transport_state)
    `CHK("radio", 1'b0, radio_enable)
    rchk("mask", `ICEL_A_MASK, 32'h0000_0BFB);
    for (i = 0; i < 16; i++) begin
      f = (i == 0) ? 12'h080 : (i == 1) ? 12'h800 : 12'($random(seed));
      f[4:3] = f[4:3] & ~f[6:5];
      @(posedge pclk);
      t_in <= 16'($random(seed));
      t_out <= 16'($random(seed));
      fl <= $random(seed);
      pw <= $random(seed);
      drive(f & 12'hBFB);
      rchk("info", `ICEL_A_INFO, {20'h0, fw});
      rchk("t_in", `ICEL_A_T_IN, e_t(fw[5], fw[3], t_in));
      rchk("t_out", `ICEL_A_T_OUT, e_t(fw[6], fw[4], t_out));
      rchk("flow", `ICEL_A_FLOW, (|fw[9:8]) ? 32'h0 : fl);
      rchk("power", `ICEL_A_POWER, (|fw[6:3] || |fw[9:8]) ? 32'h0 : pw);
    end
    rchk("events", `ICEL_A_EVENT_CNT, 32'h0);
    $display("test faults done");
    drive(12'h000);
    pulse(3);
    `CHK("radio", 1'b1, radio_enable)
    `CHK("transport", 1'b1, transport_state)
    pulse(1);
    `CHK("radio", 1'b0, radio_enable)
    pulse(0);
    `CHK("transport", 1'b0, transport_state)
    `CHK("radio", 1'b1, radio_enable)
    pulse(1);
    @(posedge pclk);
    ctl[4] <= 1'b1;
    pulse(0);
    `CHK("radio", 1'b0, radio_enable)
    ctl[4] <= 1'b0;
    pulse(1);
    pulse(2);
    `CHK("menu", 1'b0, config_menu_open)
    `CHK("transport", 1'b0, transport_state)
    pulse(5);
    `CHK("menu", 1'b1, config_menu_open)
    `CHK("transport", 1'b0, transport_state)
    pulse(6);
    rd(`ICEL_A_STATUS);
    `CHK("cfg fill", 5'h02, q[19:15])
    wr(`ICEL_A_LOG_SEL, 32'h0000_0000);
    rchk("cfg num", `ICEL_A_CFG_NUM, 32'hFFFF_FFFF);
    rchk("cfg hours", `ICEL_A_CFG_HOURS, 32'h0000_0000);
    $display("test transport done");
    wr(`ICEL_A_MASK, 32'h0000_0003);
    rd(`ICEL_A_STATUS);
    p = q[8:3];
    rd(`ICEL_A_EVENT_CNT);
    c = q;
    r0 = $random(seed);
    @(posedge pclk);
    {rv, tm, dst} <= {r0, 1'b0, r0[31:1], 1'b1};
    drive(12'h001);
    rchk("events", `ICEL_A_EVENT_CNT, c + 1);
    @(posedge pclk);
    {rv, dst} <= {~r0, 1'b0};
    drive(12'h009);
    rchk("events", `ICEL_A_EVENT_CNT, c + 1);
    drive(12'h000);
    rchk("events", `ICEL_A_EVENT_CNT, c + 2);
    wr(`ICEL_A_MASK, 32'h0000_0BFB);
    wr(`ICEL_A_LOG_SEL, p);
    rchk("log info", `ICEL_A_LOG_INFO, 32'h0000_0001);
    rchk("log heat", `ICEL_A_LOG_HEAT, r0);
    rchk("log cool", `ICEL_A_LOG_COOL, ~r0);
    rchk("log time", `ICEL_A_LOG_TIME, {1'b0, r0[31:1]});
    wr(`ICEL_A_CONTROL, 32'h0000_0001);
    rchk("log time dst", `ICEL_A_LOG_TIME, {1'b0, r0[31:1]} + 32'd3600);
    wr(`ICEL_A_LOG_SEL, (p + 1) % 50);
    rchk("log info", `ICEL_A_LOG_INFO, 32'h0000_0000);
    wr(12'hFFC, r0);
    rchk("unmapped", 12'hFFC, 32'h0);
    `CHK("slverr", 1'b0, pslverr)
    $display("test events done");
    pulse(1);
    `CHK("transport", 1'b1, transport_state)
    close_out;
  end
endmodule // tb_top
